// ==== rtl/qdl_consts.svh ====
// Functional notes
// - One 16-bit received word alone picks the channel, the mode, the power-down state and the code.
// - Each of the four channels holds its own 12-bit code, and all four outputs share one reference.
// - Two mode bits in the word choose between loading one channel, updating one channel, updating all four at once and power-down.
// - After reset every channel output is zero until the first complete valid frame is accepted.
// - Low frame sync enables the shift register, and high frame sync keeps it from taking bits.
// - After sync falls, data is sampled on each falling serial clock edge, and the host keeps it valid there.
// - The word is applied and the addressed outputs update on the 16th falling clock edge.
// - Sync rising before the 16th edge aborts the frame and discards the partial word.
// - A power-down condition chosen in the word offers three output termination choices.
`ifndef QDL_CONSTS_SVH
`define QDL_CONSTS_SVH

// Serial word layout
`define QDL_WORD_BITS 16
`define QDL_CODE_BITS 12
`define QDL_CHANS 4
`define QDL_CNT_W 5
`define QDL_LAST_BIT 5'h0f
`define QDL_SEL_HI 15
`define QDL_SEL_LO 14
`define QDL_MODE_HI 13
`define QDL_MODE_LO 12
`define QDL_CODE_HI 11

// Host clock limit, for reference in timing checks
`define QDL_SCLK_MAX_MHZ 40

// APB register map
`define QDL_ADDR_W 8
`define QDL_OFS_CTRL 8'h00
`define QDL_OFS_STATUS 8'h04
`define QDL_OFS_WORD 8'h08
`define QDL_OFS_FRAMES 8'h0c
`define QDL_OFS_CH0 8'h10
`define QDL_OFS_CH1 8'h14
`define QDL_OFS_CH2 8'h18
`define QDL_OFS_CH3 8'h1c

// Register fields and reset values
`define QDL_CTRL_EN_BIT 0
`define QDL_STAT_BUSY_BIT 0
`define QDL_STAT_ABORT_BIT 1
`define QDL_STAT_PD_BIT 2
`define QDL_CTRL_RST 1'h1
`define QDL_FRAMES_W 16

`endif

// ==== rtl/qdl_pkg.sv ====
package qdl_pkg;
	`include "qdl_consts.svh"

	typedef logic [`QDL_CODE_BITS-1:0] qdl_code_t;
	typedef logic [`QDL_CHANS-1:0][`QDL_CODE_BITS-1:0] qdl_codes_t;
	typedef logic [`QDL_WORD_BITS-1:0] qdl_word_t;

	typedef enum logic [1:0] {
		QDL_MODE_LOAD = 2'b00,
		QDL_MODE_UPDATE = 2'b01,
		QDL_MODE_ALL = 2'b10,
		QDL_MODE_PD = 2'b11
	} qdl_mode_e;

	typedef enum logic [1:0] {
		QDL_TERM_NONE = 2'b00,
		QDL_TERM_1K = 2'b01,
		QDL_TERM_100K = 2'b10,
		QDL_TERM_HIZ = 2'b11
	} qdl_term_e;
endpackage : qdl_pkg

// ==== rtl/qdl_word_if.sv ====
`timescale 1ns/1ps
interface qdl_word_if;
	logic enable;
	logic valid;
	logic abort;
	logic busy;
	qdl_pkg::qdl_word_t word;

	modport rx (input enable, output valid, output abort, output busy, output word);
	modport core (output enable, input valid, input abort, input busy, input word);
endinterface : qdl_word_if

// ==== rtl/qdl_frame_rx.sv ====
`timescale 1ns/1ps
`include "qdl_consts.svh"
module qdl_frame_rx (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial pins
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic din,
	// Received words
	qdl_word_if.rx lnk
);
	import qdl_pkg::*;

	logic sync_s1_q, sync_s2_q, sync_s3_q;
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic din_s1_q, din_s2_q;
	logic [`QDL_CNT_W-1:0] cnt_q;
	qdl_word_t shreg_q;
	qdl_word_t word_q;
	logic done_q, valid_q, abort_q, busy_q;
	logic fall, take, sync_rise, last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_s1_q <= 1'h1;
			sync_s2_q <= 1'h1;
			sync_s3_q <= 1'h1;
			sclk_s1_q <= 1'h0;
			sclk_s2_q <= 1'h0;
			sclk_s3_q <= 1'h0;
			din_s1_q <= 1'h0;
			din_s2_q <= 1'h0;
		end else begin
			sync_s1_q <= sync_n;
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			din_s1_q <= din;
			din_s2_q <= din_s1_q;
		end
	end

	assign fall = sclk_s3_q & ~sclk_s2_q;
	assign take = fall & ~sync_s2_q & ~done_q & lnk.enable;
	assign sync_rise = sync_s2_q & ~sync_s3_q;
	assign last = take && (cnt_q == `QDL_LAST_BIT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			done_q <= 1'h0;
		end else if (sync_s2_q) begin
			cnt_q <= '0;
			done_q <= 1'h0;
		end else if (take) begin
			cnt_q <= cnt_q + `QDL_CNT_W'(1);
			done_q <= last;
		end
	end

	// Msb first: new bit enters at the bottom
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg_q <= '0;
		end else if (take) begin
			shreg_q <= {shreg_q[`QDL_WORD_BITS-2:0], din_s2_q};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_q <= 1'h0;
			word_q <= '0;
			abort_q <= 1'h0;
			busy_q <= 1'h0;
		end else begin
			valid_q <= last;
			if (last) begin
				word_q <= {shreg_q[`QDL_WORD_BITS-2:0], din_s2_q};
			end
			abort_q <= sync_rise && (cnt_q != '0) && !done_q;
			busy_q <= ~sync_s2_q & ~done_q & lnk.enable;
		end
	end

	assign lnk.valid = valid_q;
	assign lnk.word = word_q;
	assign lnk.abort = abort_q;
	assign lnk.busy = busy_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_last_edge;
		take && (cnt_q == `QDL_LAST_BIT);
	endsequence

	sequence s_early_rise;
		sync_rise && (cnt_q != '0) && !done_q;
	endsequence

	sync_idle_a: assert property (sync_s2_q |=> cnt_q == '0)
		else $error("bit counter not cleared while sync high");
	bit_sample_a: assert property (take |=> shreg_q[0] == $past(din_s2_q))
		else $error("data bit not taken at falling edge");
	word_done_a: assert property (s_last_edge |=> valid_q ##1 !valid_q)
		else $error("word not delivered on sixteenth edge");
	frame_abort_a: assert property (s_early_rise |=> abort_q && !valid_q)
		else $error("short frame not aborted");
	extra_edges_a: assert property (done_q && !sync_s2_q |=> $stable(cnt_q) && !valid_q)
		else $error("edges after the word were not ignored");
endmodule : qdl_frame_rx

// ==== rtl/qdl_top.sv ====
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "qdl_consts.svh"
module qdl_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`QDL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic din,
	// Converter outputs
	output qdl_pkg::qdl_codes_t chan_code_q,
	output qdl_pkg::qdl_term_e pd_term_q,
	output logic pd_active_q
);
	import qdl_pkg::*;

	qdl_word_if lnk ();

	qdl_frame_rx u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.sync_n(sync_n),
		.sclk(sclk),
		.din(din),
		.lnk(lnk)
	);

	qdl_codes_t in_q;
	qdl_word_t last_word_q;
	logic [`QDL_FRAMES_W-1:0] frames_q;
	logic link_en_q, abort_seen_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic setup, wr_acc;
	logic [1:0] w_sel;
	qdl_mode_e w_mode;
	qdl_code_t w_code;

	function automatic logic reg_known(input logic [`QDL_ADDR_W-1:0] a);
		reg_known = (a == `QDL_OFS_CTRL) || (a == `QDL_OFS_STATUS) ||
			(a == `QDL_OFS_WORD) || (a == `QDL_OFS_FRAMES) ||
			(a == `QDL_OFS_CH0) || (a == `QDL_OFS_CH1) ||
			(a == `QDL_OFS_CH2) || (a == `QDL_OFS_CH3);
	endfunction : reg_known

	function automatic logic [31:0] pad_code(input qdl_code_t c);
		pad_code = {20'h00000, c};
	endfunction : pad_code

	// Word fields: select, mode, code
	assign w_sel = lnk.word[`QDL_SEL_HI:`QDL_SEL_LO];
	assign w_mode = qdl_mode_e'(lnk.word[`QDL_MODE_HI:`QDL_MODE_LO]);
	assign w_code = lnk.word[`QDL_CODE_HI:0];
	assign lnk.enable = link_en_q;

	// Input holding registers and outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_q <= '0;
			chan_code_q <= '0;
		end else if (lnk.valid) begin
			unique case (w_mode)
				QDL_MODE_LOAD: begin
					in_q[w_sel] <= w_code;
				end
				QDL_MODE_UPDATE: begin
					in_q[w_sel] <= w_code;
					chan_code_q[w_sel] <= w_code;
				end
				QDL_MODE_ALL: begin
					for (int i = 0; i < `QDL_CHANS; i++) begin
						in_q[i] <= w_code;
						chan_code_q[i] <= w_code;
					end
				end
				QDL_MODE_PD: begin
				end
			endcase
		end
	end

	// Power-down: termination carried in the select field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_term_q <= QDL_TERM_NONE;
			pd_active_q <= 1'h0;
		end else if (lnk.valid) begin
			if (w_mode == QDL_MODE_PD) begin
				pd_term_q <= qdl_term_e'(w_sel);
				pd_active_q <= (w_sel != 2'h0);
			end else if (w_mode != QDL_MODE_LOAD) begin
				pd_term_q <= QDL_TERM_NONE;
				pd_active_q <= 1'h0;
			end
		end
	end

	// Last accepted word and frame count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_word_q <= '0;
			frames_q <= '0;
		end else if (lnk.valid) begin
			last_word_q <= lnk.word;
			frames_q <= frames_q + `QDL_FRAMES_W'(1);
		end
	end

	// APB: one wait-free access cycle after setup
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready_q && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !reg_known(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_en_q <= `QDL_CTRL_RST;
		end else if (wr_acc && (paddr == `QDL_OFS_CTRL)) begin
			link_en_q <= pwdata[`QDL_CTRL_EN_BIT];
		end
	end

	// Abort flag: a new abort wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_seen_q <= 1'h0;
		end else if (lnk.abort) begin
			abort_seen_q <= 1'h1;
		end else if (wr_acc && (paddr == `QDL_OFS_STATUS) && pwdata[`QDL_STAT_ABORT_BIT]) begin
			abort_seen_q <= 1'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (setup && !pwrite) begin
			prdata_q <= '0;
			case (paddr)
				`QDL_OFS_CTRL: prdata_q[`QDL_CTRL_EN_BIT] <= link_en_q;
				`QDL_OFS_STATUS: begin
					prdata_q[`QDL_STAT_BUSY_BIT] <= lnk.busy;
					prdata_q[`QDL_STAT_ABORT_BIT] <= abort_seen_q;
					prdata_q[`QDL_STAT_PD_BIT] <= pd_active_q;
				end
				`QDL_OFS_WORD: prdata_q <= {16'h0000, last_word_q};
				`QDL_OFS_FRAMES: prdata_q <= {16'h0000, frames_q};
				`QDL_OFS_CH0: prdata_q <= pad_code(chan_code_q[0]);
				`QDL_OFS_CH1: prdata_q <= pad_code(chan_code_q[1]);
				`QDL_OFS_CH2: prdata_q <= pad_code(chan_code_q[2]);
				`QDL_OFS_CH3: prdata_q <= pad_code(chan_code_q[3]);
				default: prdata_q <= '0;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Helper: any word accepted since reset
	logic seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 1'h0;
		end else if (lnk.valid) begin
			seen_q <= 1'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_all_write;
		lnk.valid && (w_mode == QDL_MODE_ALL);
	endsequence

	sequence s_one_write;
		lnk.valid && (w_mode == QDL_MODE_UPDATE);
	endsequence

	zero_start_a: assert property (!seen_q |-> chan_code_q == '0)
		else $error("outputs not zero before first word");
	all_update_a: assert property (s_all_write |=> chan_code_q ==
		{`QDL_CHANS{$past(w_code)}})
		else $error("all-channel write did not reach every output");
	one_update_a: assert property (s_one_write |=>
		chan_code_q[$past(w_sel)] == $past(w_code) && in_q[$past(w_sel)] == $past(w_code))
		else $error("addressed channel not updated");
	hold_idle_a: assert property (!lnk.valid |=> $stable(chan_code_q))
		else $error("outputs changed without a word");
	abort_hold_a: assert property (lnk.abort |=> $stable(chan_code_q) [*2])
		else $error("aborted frame changed outputs");
	word_keep_a: assert property (lnk.valid |=> last_word_q == $past(lnk.word))
		else $error("accepted word not kept");
	pd_select_a: assert property (lnk.valid && w_mode == QDL_MODE_PD |=>
		pd_term_q == $past(w_sel) && pd_active_q == ($past(w_sel) != 2'h0))
		else $error("power-down termination not applied");
	apb_answer_a: assert property (setup |=> pready_q ##1 !pready_q)
		else $error("APB answer not one cycle after setup");
endmodule : qdl_top

// ==== tb/qdl_host_model.sv ====
`timescale 1ns/1ps
module qdl_host_model (
	// Serial link pins
	output logic sync_n,
	output logic sclk,
	output logic din
);
	initial begin
		sync_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end

	// Sends nbits of w MSB first, then extra edges with sync still low
	task automatic send(input logic [15:0] w, input int nbits, input int extra);
		sync_n = 1'b0;
		#63;
		for (int i = 0; i < nbits + extra; i++) begin
			din = (i < 16) ? w[15-i] : ~din;
			#62 sclk = 1'b0;
			#63 sclk = 1'b1;
		end
		sync_n = 1'b1;
		din = ~din;
		#125;
	endtask : send
endmodule : qdl_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import qdl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_n, sclk, din, pd_active_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	qdl_codes_t chan_code_q;
	qdl_term_e pd_term_q;
	int n_errors = 0;
	int checks = 0;

	qdl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_n(sync_n), .sclk(sclk), .din(din),
		.chan_code_q(chan_code_q), .pd_term_q(pd_term_q), .pd_active_q(pd_active_q));
	qdl_host_model host_u (.sync_n(sync_n), .sclk(sclk), .din(din));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("access cycles", 48'h1, n);
		rd = prdata;
		chk("pslverr", {47'h0, (a > 8'h1c)}, {47'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic frame(input logic [15:0] w, input int nbits, input int extra);
		host_u.send(w, nbits, extra);
		repeat (10) @(posedge pclk);
	endtask : frame

	initial begin
		#200us;
		n_errors++;
		print_verdict();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("codes after reset", 48'h0, chan_code_q);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 48'h1, {16'h0, rd});
		frame(16'h9abc, 16, 0);
		chk("single update", 48'h000abc000000, chan_code_q);
		apb(1'b0, 8'h18, 32'h0);
		chk("ch2 reg", 48'habc, {16'h0, rd});
		frame(16'h4123, 16, 0);
		chk("load only", 48'h000abc000000, chan_code_q);
		frame(16'hdfff, 10, 0);
		chk("aborted frame", 48'h000abc000000, chan_code_q);
		apb(1'b0, 8'h04, 32'h0);
		chk("abort flag", 48'h2, {16'h0, rd & 32'h2});
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk("abort cleared", 48'h0, {16'h0, rd & 32'h2});
		frame(16'h25a5, 16, 4);
		chk("all update", 48'h5a55a55a55a5, chan_code_q);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk("last word", 48'h25a5, {16'h0, rd});
		for (int t = 1; t < 4; t++) begin
			frame({t[1:0], 2'b11, 12'h000}, 16, 0);
			chk("pd term", t, {46'h0, pd_term_q});
			chk("pd active", 48'h1, {47'h0, pd_active_q});
			chk("pd codes", 48'h5a55a55a55a5, chan_code_q);
			apb(1'b0, 8'h04, 32'h0);
			chk("pd status", 48'h4, {16'h0, rd & 32'h4});
		end
		frame(16'h17ff, 16, 0);
		chk("wake", 48'h0, {47'h0, pd_active_q});
		chk("wake codes", 48'h5a55a55a57ff, chan_code_q);
		apb(1'b1, 8'h00, 32'h0);
		frame(16'h9fff, 16, 0);
		chk("disabled link", 48'h5a55a55a57ff, chan_code_q);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk("frame count", 48'h7, {16'h0, rd});
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped read", 48'h0, {16'h0, rd});
		print_verdict();
	end
endmodule : testbench
